// >>> design/hotplug_slot_defs.svh
`ifndef HOTPLUG_SLOT_DEFS_SVH
`define HOTPLUG_SLOT_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SLOT_WORD_ADDR   12'h0D8
`define EVENT_MASK_ADDR  12'h0DC

// ----------------------------------------------------------------
// Slot control fields, bit positions in bits 15:0
// ----------------------------------------------------------------
`define CT_BTN_EN        0
`define CT_PF_EN         1
`define CT_PD_EN         3
`define CT_CC_EN         4
`define CT_HP_INT_EN     5
`define CT_ATTN_LSB      6
`define CT_PWR_IND_LSB   8
`define CT_PWR_OFF       10
`define CT_DLL_EN        12

// ----------------------------------------------------------------
// Slot status fields, bit positions relative to bit 16
// ----------------------------------------------------------------
`define EV_BTN           0
`define EV_PF            1
`define EV_LATCH_CHG     2
`define EV_PD_CHG        3
`define EV_CC            4
`define ST_LATCH         5
`define ST_PD            6
`define EV_DLL           8

// ----------------------------------------------------------------
// Indicator encodings, reset values and counts
// ----------------------------------------------------------------
`define IND_RESERVED     2'h0
`define IND_ON           2'h1
`define IND_BLINK        2'h2
`define IND_OFF          2'h3
`define PWR_OFF_RST      1'b0
`define DLL_CHG_RST      1'b1
`define MASK_RST         16'h011B
`define PRIME_LOAD       2'h2
`define PRIME_DONE       2'h3

`endif

// >>> design/hotplug_slot_pkg.sv
package hotplug_slot_pkg;

    typedef struct packed {
        logic       dll_en;
        logic       pwr_off;
        logic [1:0] pwr_ind;
        logic [1:0] attn_ind;
        logic       hp_int_en;
        logic       cc_en;
        logic       pd_en;
        logic       pf_en;
        logic       btn_en;
    } slot_ctrl_type;

    typedef struct packed {
        logic dll;
        logic cc;
        logic pd;
        logic latch;
        logic pf;
        logic btn;
    } event_type;

    typedef struct packed {
        logic button;
        logic power_fault;
        logic latch_open;
        logic presence_strap;
    } sensor_type;

    typedef struct packed {
        logic       is_power;
        logic [1:0] state;
    } ind_msg_type;

    typedef enum logic [2:0] {
        SEND_IDLE  = 3'b001,
        SEND_ATTN  = 3'b010,
        SEND_POWER = 3'b100
    } send_state_type;

    typedef struct packed {
        sensor_type stage1;
        sensor_type stage2;
    } sync_state_type;

    typedef struct packed {
        send_state_type fsm;
        logic           attn_pend;
        logic           pwr_pend;
        logic [1:0]     attn_val;
        logic [1:0]     pwr_val;
        ind_msg_type    data;
    } sender_state_type;

    typedef struct packed {
        slot_ctrl_type ctrl;
        event_type     flags;
        event_type     mask;
        logic          latch_state;
        logic          presence;
        logic [1:0]    prime;
        logic          btn_prev;
        logic          pf_prev;
        logic          link_prev;
        logic          cmd_pending;
        logic [31:0]   rdata;
        logic          err;
    } slot_state_type;

endpackage

// >>> design/sensor_sync.sv
module sensor_sync (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire hotplug_slot_pkg::sensor_type d,
    output hotplug_slot_pkg::sensor_type   q
);
    import hotplug_slot_pkg::*;

    sync_state_type s;
    sync_state_type next_s;

    // Stage one feeds stage two only
    always_comb begin
        next_s        = s;
        next_s.stage1 = d;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stage2;
endmodule

// >>> design/indicator_msg_sender.sv
`include "hotplug_slot_defs.svh"

module indicator_msg_sender (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       attn_write,
    input  wire logic [1:0]                 attn_value,
    input  wire logic                       pwr_write,
    input  wire logic [1:0]                 pwr_value,
    output logic                            msg_valid,
    output hotplug_slot_pkg::ind_msg_type   msg_data,
    input  wire logic                       msg_ready,
    output logic                            busy
);
    import hotplug_slot_pkg::*;

    sender_state_type s;
    sender_state_type next_s;

    always_comb begin
        next_s = s;
        case (s.fsm)
            SEND_IDLE: begin
                if (s.attn_pend) begin
                    next_s.fsm       = SEND_ATTN;
                    next_s.attn_pend = 1'b0;
                    next_s.data      = '{is_power: 1'b0, state: s.attn_val};
                end else if (s.pwr_pend) begin
                    next_s.fsm      = SEND_POWER;
                    next_s.pwr_pend = 1'b0;
                    next_s.data     = '{is_power: 1'b1, state: s.pwr_val};
                end
            end
            SEND_ATTN, SEND_POWER: begin
                if (msg_ready) begin
                    next_s.fsm = SEND_IDLE;
                end
            end
            default: begin
                next_s.fsm = SEND_IDLE;
            end
        endcase
        // A new write re-arms even while its last copy is dispatched
        if (attn_write) begin
            next_s.attn_pend = 1'b1;
            next_s.attn_val  = attn_value;
        end
        if (pwr_write) begin
            next_s.pwr_pend = 1'b1;
            next_s.pwr_val  = pwr_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{fsm: SEND_IDLE, attn_val: `IND_OFF, pwr_val: `IND_OFF, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign msg_valid = (s.fsm != SEND_IDLE);
    assign msg_data  = s.data;
    assign busy      = msg_valid | s.attn_pend | s.pwr_pend;
endmodule

// >>> design/hotplug_slot_control_status.sv
// Added by the designer: register access over APB.
`include "hotplug_slot_defs.svh"

module hotplug_slot_control_status (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     attention_button,
    input  wire logic                     power_fault,
    input  wire logic                     retention_latch,
    input  wire logic                     slot_presence_strap,
    input  wire logic                     link_active,
    input  wire logic                     slot_implemented,
    output logic                          msg_valid,
    output hotplug_slot_pkg::ind_msg_type msg_data,
    input  wire logic                     msg_ready,
    output logic                          slot_power_off,
    output logic                          hp_irq
);
    import hotplug_slot_pkg::*;

    // ----------------------------------------------------------------
    // Field packing
    // ----------------------------------------------------------------
    function automatic logic [15:0] ctrl_word(slot_ctrl_type c);
        logic [15:0] w;
        w                                      = 16'h0000;
        w[`CT_BTN_EN]                          = c.btn_en;
        w[`CT_PF_EN]                           = c.pf_en;
        w[`CT_PD_EN]                           = c.pd_en;
        w[`CT_CC_EN]                           = c.cc_en;
        w[`CT_HP_INT_EN]                       = c.hp_int_en;
        w[`CT_ATTN_LSB +: 2]                   = c.attn_ind;
        w[`CT_PWR_IND_LSB +: 2]                = c.pwr_ind;
        w[`CT_PWR_OFF]                         = c.pwr_off;
        w[`CT_DLL_EN]                          = c.dll_en;
        return w;
    endfunction

    function automatic slot_ctrl_type word_ctrl(logic [15:0] w);
        slot_ctrl_type c;
        c.btn_en    = w[`CT_BTN_EN];
        c.pf_en     = w[`CT_PF_EN];
        c.pd_en     = w[`CT_PD_EN];
        c.cc_en     = w[`CT_CC_EN];
        c.hp_int_en = w[`CT_HP_INT_EN];
        c.attn_ind  = w[`CT_ATTN_LSB +: 2];
        c.pwr_ind   = w[`CT_PWR_IND_LSB +: 2];
        c.pwr_off   = w[`CT_PWR_OFF];
        c.dll_en    = w[`CT_DLL_EN];
        return c;
    endfunction

    function automatic logic [15:0] event_word(event_type e);
        logic [15:0] w;
        w                = 16'h0000;
        w[`EV_BTN]       = e.btn;
        w[`EV_PF]        = e.pf;
        w[`EV_LATCH_CHG] = e.latch;
        w[`EV_PD_CHG]    = e.pd;
        w[`EV_CC]        = e.cc;
        w[`EV_DLL]       = e.dll;
        return w;
    endfunction

    function automatic event_type word_event(logic [15:0] w);
        event_type e;
        e.btn   = w[`EV_BTN];
        e.pf    = w[`EV_PF];
        e.latch = w[`EV_LATCH_CHG];
        e.pd    = w[`EV_PD_CHG];
        e.cc    = w[`EV_CC];
        e.dll   = w[`EV_DLL];
        return e;
    endfunction

    // ----------------------------------------------------------------
    // Pins and state
    // ----------------------------------------------------------------
    slot_state_type s;
    slot_state_type next_s;
    sensor_type     pins_raw;
    sensor_type     pins;
    event_type      set_ev;
    event_type      clr_ev;
    logic [15:0]    ctrl_now;
    logic [15:0]    merged_ctrl;
    logic [15:0]    status_hi;
    logic           setup;
    logic           access;
    logic           sel_slot;
    logic           sel_mask;
    logic           wr_lo;
    logic           wr_hi;
    logic           ctrl_wr;
    logic           ind_busy;
    logic           present_rd;

    assign pins_raw = '{button:         attention_button,
                        power_fault:    power_fault,
                        latch_open:     retention_latch,
                        presence_strap: slot_presence_strap};

    sensor_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pins_raw),
        .q       (pins)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign setup    = psel & ~penable;
    assign access   = psel & penable;
    assign sel_slot = (paddr == `SLOT_WORD_ADDR);
    assign sel_mask = (paddr == `EVENT_MASK_ADDR);
    assign wr_lo    = access & pwrite & sel_slot & pstrb[0];
    assign wr_hi    = access & pwrite & sel_slot & pstrb[1];
    assign ctrl_wr  = wr_lo | wr_hi;

    // Unstrobed lanes keep their stored fields
    assign ctrl_now    = ctrl_word(s.ctrl);
    assign merged_ctrl = {(pstrb[1] ? pwdata[15:8] : ctrl_now[15:8]),
                          (pstrb[0] ? pwdata[7:0]  : ctrl_now[7:0])};

    // Latch changed is read-only, so it never takes a clear
    always_comb begin
        clr_ev = word_event({(pstrb[3] ? pwdata[31:24] : 8'h00),
                             (pstrb[2] ? pwdata[23:16] : 8'h00)});
        clr_ev.latch = 1'b0;
        if (!(access && pwrite && sel_slot)) begin
            clr_ev = '0;
        end
    end

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    always_comb begin
        set_ev       = '0;
        set_ev.btn   = pins.button & ~s.btn_prev;
        set_ev.pf    = pins.power_fault & ~s.pf_prev;
        set_ev.latch = (s.prime == `PRIME_DONE) &&
                       (pins.latch_open != s.latch_state);
        set_ev.pd    = (s.prime == `PRIME_DONE) &&
                       (~pins.presence_strap != s.presence);
        set_ev.cc    = s.cmd_pending & ~ind_busy & ~ctrl_wr;
        set_ev.dll   = (link_active != s.link_prev);
    end

    assign present_rd = slot_implemented ? s.presence : 1'b1;

    always_comb begin
        status_hi              = event_word(s.flags);
        status_hi[`ST_LATCH]   = s.latch_state;
        status_hi[`ST_PD]      = present_rd;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.btn_prev  = pins.button;
        next_s.pf_prev   = pins.power_fault;
        next_s.link_prev = link_active;
        if (s.prime != `PRIME_DONE) begin
            next_s.prime = s.prime + 2'h1;
        end
        // Sensors are unknown until the synchroniser has filled
        if (s.prime >= `PRIME_LOAD) begin
            next_s.presence    = ~pins.presence_strap;
            next_s.latch_state = pins.latch_open;
        end
        // Set wins over a clear landing in the same cycle
        next_s.flags = event_type'((s.flags & ~clr_ev) | set_ev);

        if (ctrl_wr) begin
            next_s.ctrl        = word_ctrl(merged_ctrl);
            next_s.cmd_pending = 1'b1;
        end else if (set_ev.cc) begin
            next_s.cmd_pending = 1'b0;
        end
        if (access && pwrite && sel_mask && pstrb[2]) begin
            next_s.mask = word_event({s.mask.dll ? 8'h01 : 8'h00, pwdata[23:16]});
        end
        if (access && pwrite && sel_mask && pstrb[3]) begin
            next_s.mask.dll = pwdata[24];
        end

        // Read data is captured in the setup cycle, shown in access
        if (setup) begin
            next_s.err = ~(sel_slot | sel_mask);
            if (pwrite) begin
                next_s.rdata = 32'h0000_0000;
            end else if (sel_slot) begin
                next_s.rdata = {status_hi, ctrl_word(s.ctrl)};
            end else if (sel_mask) begin
                next_s.rdata = {event_word(s.mask), 16'h0000};
            end else begin
                next_s.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{ctrl: '{attn_ind: `IND_OFF, pwr_ind: `IND_OFF,
                           pwr_off: `PWR_OFF_RST, default: 1'b0},
                   flags: '{dll: `DLL_CHG_RST, default: 1'b0},
                   mask: word_event(`MASK_RST),
                   default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Indicator messages
    // ----------------------------------------------------------------
    indicator_msg_sender u_sender (
        .pclk       (pclk),
        .presetn    (presetn),
        .attn_write (wr_lo),
        .attn_value (pwdata[`CT_ATTN_LSB +: 2]),
        .pwr_write  (wr_hi),
        .pwr_value  (pwdata[`CT_PWR_IND_LSB +: 2]),
        .msg_valid  (msg_valid),
        .msg_data   (msg_data),
        .msg_ready  (msg_ready),
        .busy       (ind_busy)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata         = s.rdata;
    assign pready         = 1'b1;
    assign pslverr        = access & s.err;
    assign slot_power_off = s.ctrl.pwr_off;

    // Latch changed has no enable of its own, so it never interrupts
    assign hp_irq = s.ctrl.hp_int_en &
                    ((s.flags.btn & s.ctrl.btn_en & s.mask.btn) |
                     (s.flags.pf  & s.ctrl.pf_en  & s.mask.pf)  |
                     (s.flags.pd  & s.ctrl.pd_en  & s.mask.pd)  |
                     (s.flags.cc  & s.ctrl.cc_en  & s.mask.cc)  |
                     (s.flags.dll & s.ctrl.dll_en & s.mask.dll));

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_attn_msg_sent: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_lo && !ind_busy) |-> ##2 (msg_valid && !msg_data.is_power &&
                                      msg_data.state == $past(pwdata[7:6], 2)))
        else $error("attention write produced no matching message");

    a_attn_field_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_lo |=> (s.ctrl.attn_ind == $past(pwdata[7:6])))
        else $error("attention field did not take the written value");

    a_latch_flag_ro: assert property (
        @(posedge pclk) disable iff (!presetn)
        s.flags.latch |=> s.flags.latch)
        else $error("latch changed flag cleared by a write");

    a_power_msg_sent: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_hi && !wr_lo && !ind_busy) |-> ##2 (msg_valid && msg_data.is_power &&
                                                msg_data.state == $past(pwdata[9:8], 2)))
        else $error("power indicator write produced no message");

    a_power_ctrl_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_hi |=> (slot_power_off == $past(pwdata[10])))
        else $error("slot power control did not follow the write");

    a_button_flag_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pins.button && !s.btn_prev) |=> s.flags.btn)
        else $error("button press did not set its flag");

    a_fault_flag_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s.flags.pf && wr_hi == 1'b0 && access && pwrite && sel_slot && pstrb[2] &&
         pwdata[17] && !set_ev.pf) |=> !s.flags.pf)
        else $error("power fault flag not cleared by write of one");

    a_cmd_done_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(s.flags.cc) |-> $past(s.cmd_pending) && !$past(ind_busy))
        else $error("command completed without a pending command");

    a_no_slot_present: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel_slot && !slot_implemented) |=> prdata[22])
        else $error("presence read zero on a port without a slot");

    a_link_change_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        (link_active != $past(link_active)) |-> ##1 s.flags.dll)
        else $error("link active change did not set its flag");

    a_irq_master_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_lo && !pwdata[`CT_HP_INT_EN]) |=> !hp_irq)
        else $error("interrupt raised with master enable off");

    a_reserved_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite && sel_slot) |-> ((prdata & 32'hFE80_E800) == 32'h0000_0000))
        else $error("reserved bits read nonzero");

    a_presence_change: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s.prime == `PRIME_DONE && pins.presence_strap == s.presence) |=> s.flags.pd)
        else $error("presence change not flagged");
endmodule

// >>> dv/slot_model.sv
module slot_model (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          msg_valid,
    input  wire hotplug_slot_pkg::ind_msg_type msg_data,
    input  wire logic                          stall,
    output logic                               msg_ready,
    output logic [3:0]                         msg_count
);
    timeunit 1ns;
    timeprecision 1ps;
    import hotplug_slot_pkg::*;

    // ----------------------------------------
    // Indicator message acceptor
    // ----------------------------------------
    // Ready lags stall by a cycle, as a slow link partner would
    ind_msg_type log [16];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_ready <= 1'b0;
            msg_count <= 4'h0;
        end else begin
            msg_ready <= !stall;
            if (msg_valid && msg_ready) begin
                log[msg_count] <= msg_data;
                msg_count      <= msg_count + 4'h1;
            end
        end
    end
endmodule

// >>> dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hotplug_slot_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        attention_button = 1'b0;
    logic        power_fault = 1'b0;
    logic        retention_latch = 1'b0;
    logic        slot_presence_strap = 1'b0;
    logic        link_active = 1'b0;
    logic        slot_implemented = 1'b1;
    logic        msg_valid;
    ind_msg_type msg_data;
    logic        msg_ready;
    logic        slot_power_off;
    logic        hp_irq;
    logic        stall = 1'b0;
    logic [3:0]  msg_count;
    logic [31:0] rd;
    logic        err;
    int          failures = 0;
    int          checks = 0;
    int          msgs = 0;

    hotplug_slot_control_status i_hotplug_slot_control_status (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .attention_button, .power_fault,
        .retention_latch, .slot_presence_strap, .link_active, .slot_implemented,
        .msg_valid, .msg_data, .msg_ready, .slot_power_off, .hp_irq
    );

    slot_model i_slot_model (
        .pclk, .presetn, .msg_valid, .msg_data, .stall, .msg_ready, .msg_count
    );

    initial begin
        forever #4 pclk = ~pclk;
    end

    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits until the slot has taken the expected number of messages
    task automatic wait_msgs();
        int n;
        n = 0;
        while (msg_count !== 4'(msgs)) begin
            @(posedge pclk);
            n++;
            if (n > 100) begin
                failures++;
                close_out();
            end
        end
        idle(2);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        idle(2);
        presetn <= 1'b1;
        idle(4);
        apb(1'b0, 12'h0D8, 32'h0, 4'h0);
        chk("reset_word", rd, 32'h0140_03C0);
        apb(1'b0, 12'h0E0, 32'h0, 4'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h0D8, 32'hFFFF_0000, 4'hC);
        apb(1'b0, 12'h0D8, 32'h0, 4'h0);
        chk("w1c_reserved", rd, 32'h0040_03C0);
        $display("test reset_and_clear done");
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, 12'h0D8, 32'(c) << 6, 4'h1);
            msgs++;
            wait_msgs();
            chk("attn_msg", {29'h0, i_slot_model.log[msgs-1]}, {30'h0, c[1:0]});
        end
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, 12'h0D8, 32'(c) << 8, 4'h2);
            msgs++;
            wait_msgs();
            chk("pwr_msg", {29'h0, i_slot_model.log[msgs-1]}, {30'h1, c[1:0]});
        end
        apb(1'b0, 12'h0D8, 32'h0, 4'h0);
        chk("cmd_done", rd, 32'h0050_03C0);
        stall <= 1'b1;
        apb(1'b1, 12'h0D8, 32'h0000_0640, 4'h3);
        idle(5);
        chk("msg_stands", {28'h0, msg_valid, msg_data}, 32'h9);
        stall <= 1'b0;
        msgs += 2;
        wait_msgs();
        chk("first_attn", {29'h0, i_slot_model.log[msgs-2]}, 32'h1);
        chk("then_power", {29'h0, i_slot_model.log[msgs-1]}, 32'h6);
        chk("power_off", {31'h0, slot_power_off}, 32'h1);
        $display("test indicators done");
        attention_button <= 1'b1;
        power_fault      <= 1'b1;
        link_active      <= 1'b1;
        idle(6);
        apb(1'b0, 12'h0D8, 32'h0, 4'h0);
        chk("events", rd & 32'h011F_0000, 32'h0113_0000);
        chk("irq_master_off", {31'h0, hp_irq}, 32'h0);
        apb(1'b1, 12'h0D8, 32'h0000_0061, 4'h1);
        msgs++;
        wait_msgs();
        chk("irq_on", {31'h0, hp_irq}, 32'h1);
        apb(1'b1, 12'h0DC, 32'h0, 4'hF);
        idle(1);
        chk("irq_masked", {31'h0, hp_irq}, 32'h0);
        apb(1'b1, 12'h0DC, 32'h011B_0000, 4'hF);
        apb(1'b1, 12'h0D8, 32'h0003_0000, 4'h4);
        idle(1);
        chk("irq_cleared", {31'h0, hp_irq}, 32'h0);
        apb(1'b0, 12'h0D8, 32'h0, 4'h0);
        chk("btn_w1c", rd & 32'h011F_0000, 32'h0110_0000);
        $display("test events_irq done");
        retention_latch     <= 1'b1;
        slot_presence_strap <= 1'b1;
        idle(6);
        apb(1'b0, 12'h0D8, 32'h0, 4'h0);
        chk("sensors", rd & 32'h006C_0000, 32'h002C_0000);
        apb(1'b1, 12'h0D8, 32'h000C_0000, 4'h4);
        apb(1'b0, 12'h0D8, 32'h0, 4'h0);
        chk("latch_ro", rd & 32'h006C_0000, 32'h0024_0000);
        slot_implemented <= 1'b0;
        idle(2);
        apb(1'b0, 12'h0D8, 32'h0, 4'h0);
        chk("no_slot", rd & 32'h0040_0000, 32'h0040_0000);
        $display("test sensors done");
        close_out();
    end
endmodule
